//--- verilog/cdi_pkg.sv
// Shared constants and types for the card interface control block
package cdi_pkg;

    // ========================================================
    // Clock and timing
    localparam int CLK_HZ        = 40_000_000;
    localparam int SPIKE_NS      = 50;
    // Longest suppressed spike, rounded down to whole cycles
    localparam int SPIKE_CYC_RAW = (SPIKE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam logic [1:0] SPIKE_CYC =
        2'((SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW);

    // ========================================================
    // Two-wire bus framing
    localparam logic [7:0] ADDR_BASE     = 8'h40;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic       LINE_IDLE     = 1'b1;

    // ========================================================
    // Control register layout
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam int CTRL_SESSION  = 0;
    localparam int CTRL_WARM     = 1;
    localparam int CTRL_VCC_3V   = 2;
    localparam int CTRL_CLK_STOP = 3;
    localparam int CTRL_STOP_HI  = 4;
    localparam int CTRL_DIV_LO   = 5;
    localparam int CTRL_DIV_HI   = 6;
    localparam int CTRL_IO_EN    = 7;

    // ========================================================
    // Status register layout
    localparam logic [7:0] STATUS_RESET  = 8'h04;
    localparam int STAT_PRES     = 0;
    localparam int STAT_PRES_CHG = 1;
    localparam int STAT_IO       = 2;
    localparam int STAT_SUPPLY   = 3;
    localparam int STAT_OVERCURRENT_HEAT_FLAG     = 4;
    localparam int STAT_MUTE     = 5;
    localparam int STAT_EARLY    = 6;
    localparam int STAT_ACTIVE   = 7;

    // ========================================================
    // Card clock: half periods in system cycles, input clock = clk/2
    localparam logic [1:0] DIV_BY8  = 2'h0;
    localparam logic [1:0] DIV_BY4  = 2'h1;
    localparam logic [1:0] DIV_BY2  = 2'h2;
    localparam logic [3:0] HALF_BY8 = 4'h8;
    localparam logic [3:0] HALF_BY4 = 4'h4;
    localparam logic [3:0] HALF_BY2 = 4'h2;
    localparam logic [3:0] HALF_BY1 = 4'h1;

    // ========================================================
    // Answer-to-reset window in card clocks
    localparam int ATR_EARLY_CLKS = 400;
    localparam int ATR_MUTE_CLKS  = 40000;

    // ========================================================
    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_ADDR_AK = 3'b010,
        ST_WR_DATA = 3'b011,
        ST_WR_AK   = 3'b100,
        ST_RD_DATA = 3'b101,
        ST_RD_AK   = 3'b110,
        ST_IGNORE  = 3'b111
    } cdi_state_t;

endpackage

//--- verilog/cdi_cclk_if.sv
// Carrier between the control core and the card clock generator
`timescale 1ns/1ps
interface cdi_cclk_if;
    logic [1:0] div;
    logic       stop;
    logic       stop_high;
    logic       card_clk;
    logic       card_tick;

    modport ctl (output div, stop, stop_high,
                 input  card_clk, card_tick);
    modport gen (input  div, stop, stop_high,
                 output card_clk, card_tick);
endinterface

//--- verilog/cdi_card_clk.sv
// Card clock generator with divider and stop level
`timescale 1ns/1ps
module cdi_card_clk
    import cdi_pkg::*;
(
    // System
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Control side
    cdi_cclk_if.gen   cc
);
    logic [3:0] half;
    logic [3:0] cnt;

    // ========================================================
    // Divider selection
    always_comb begin
        case (cc.div)
            DIV_BY8: half = HALF_BY8;
            DIV_BY4: half = HALF_BY4;
            DIV_BY2: half = HALF_BY2;
            default: half = HALF_BY1;
        endcase
    end

    // Half-period counter, restarts when stopped so runs begin cleanly
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= 4'h0;
        end else if (cc.stop || cnt + 4'h1 >= half) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    // Clock level; held at the chosen level while stopped
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cc.card_clk <= 1'b0;
        end else if (cc.stop) begin
            cc.card_clk <= cc.stop_high;
        end else if (cnt + 4'h1 >= half) begin
            cc.card_clk <= ~cc.card_clk;
        end
    end

    // One pulse per card clock rising edge, for window counting
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cc.card_tick <= 1'b0;
        end else begin
            cc.card_tick <= !cc.stop && (cnt + 4'h1 >= half)
                            && !cc.card_clk;
        end
    end

    chk_clk_stop_level: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        cc.stop [*2] |-> cc.card_clk == $past(cc.stop_high))
        else $error("card clock not held at stop level");

endmodule

//--- verilog/cdi_ctrl.sv
// Two-wire slave front end, control and status of one card interface
`timescale 1ns/1ps
module cdi_ctrl
    import cdi_pkg::*;
#(
    parameter int MUTE_CLKS  = ATR_MUTE_CLKS,
    parameter int EARLY_CLKS = ATR_EARLY_CLKS
) (
    // System
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // Two-wire bus
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       addr_select_bit0_i,
    input  wire logic       addr_select_bit1_i,
    input  wire logic       addr_select_bit2_i,
    // Card and supervisor status
    input  wire logic       card_present_i,
    input  wire logic       card_io_i,
    input  wire logic       vcc_on_i,
    input  wire logic       supply_fault_i,
    input  wire logic       overcurrent_heat_flag_fault_i,
    // Sequencer controls
    output logic            session_o,
    output logic            warm_reset_o,
    output logic            vcc_3v_o,
    output logic            card_clk_o,
    // Host-side card I/O
    output logic            host_side_io_o,
    output logic            host_side_io_oe_o,
    // Interrupt
    output logic            irq_n_o
);
    cdi_cclk_if cc ();
    cdi_state_t state;

    logic [1:0] raw;
    logic [1:0] filt;
    logic       scl_d;
    logic       sda_d;
    logic [3:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] card_control;
    logic       commit;
    logic       rd_clr;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       addr_hit;
    logic       pres_q;
    logic       flag_pres;
    logic       flag_supply;
    logic       flag_overcurrent_heat_flag;
    logic       flag_mute;
    logic       flag_early;
    logic       atr_run;
    logic [15:0] atr_cnt;
    logic       answer;
    logic       mute_hit;
    logic       atr_begin;
    logic [7:0] status;

    // ========================================================
    // Spike filter: a level must hold past the spike limit to pass
    assign raw = {sda_i, scl_i};
    for (genvar g = 0; g < 2; g++) begin : g_filt
        logic [1:0] cnt;
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                cnt     <= 2'h0;
                filt[g] <= LINE_IDLE;
            end else if (raw[g] == filt[g]) begin
                cnt     <= 2'h0;
            end else if (cnt == SPIKE_CYC) begin
                filt[g] <= raw[g];
                cnt     <= 2'h0;
            end else begin
                cnt     <= cnt + 2'h1;
            end
        end
    end

    // Previous filtered levels for edge and condition detection
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_d <= LINE_IDLE;
            sda_d <= LINE_IDLE;
        end else begin
            scl_d <= filt[0];
            sda_d <= filt[1];
        end
    end

    assign scl_rise  = filt[0] && !scl_d;
    assign scl_fall  = !filt[0] && scl_d;
    assign bus_start = filt[0] && scl_d && sda_d && !filt[1];
    assign bus_stop  = filt[0] && scl_d && !sda_d && filt[1];
    // Address byte compared with its direction bit masked off
    assign addr_hit  = {rx[7:1], 1'b0} == ADDR_BASE +
        {4'h0, addr_select_bit2_i, addr_select_bit1_i,
         addr_select_bit0_i, 1'b0};

    // ========================================================
    // Slave sequencer; SDA changes only after SCL falls
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state    <= ST_IDLE;
            bit_cnt  <= 4'h0;
            rx       <= 8'h00;
            tx       <= 8'h00;
            sda_oe_o <= 1'b0;
        end else if (bus_start) begin
            state    <= ST_ADDR;
            bit_cnt  <= 4'h0;
            sda_oe_o <= 1'b0;
        end else if (bus_stop) begin
            state    <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_WR_DATA: begin
                    if (scl_rise) begin
                        rx      <= {rx[6:0], filt[1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_WR_DATA) begin
                            state    <= ST_WR_AK;
                            sda_oe_o <= 1'b1;
                        end else if (addr_hit) begin
                            state    <= ST_ADDR_AK;
                            sda_oe_o <= 1'b1;
                        end else begin
                            state    <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_AK: begin
                    if (scl_fall) begin
                        if (rx[0]) begin
                            state    <= ST_RD_DATA;
                            tx       <= {status[6:0], 1'b0};
                            sda_oe_o <= !status[7];
                        end else begin
                            state    <= ST_WR_DATA;
                            sda_oe_o <= 1'b0;
                        end
                    end
                end
                ST_WR_AK: begin
                    // Extra bytes before STOP simply rewrite the register
                    if (scl_fall) begin
                        state    <= ST_WR_DATA;
                        sda_oe_o <= 1'b0;
                    end
                end
                ST_RD_DATA: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            state    <= ST_RD_AK;
                            bit_cnt  <= 4'h0;
                            sda_oe_o <= 1'b0;
                        end else begin
                            sda_oe_o <= !tx[7];
                            tx       <= {tx[6:0], 1'b0};
                        end
                    end
                end
                ST_RD_AK: begin
                    if (scl_rise) begin
                        // Master nack ends the read; ack repeats status
                        state <= filt[1] ? ST_IGNORE : ST_ADDR_AK;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    sda_oe_o <= 1'b0;
                end
                default: begin
                    state    <= ST_IDLE;
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

    assign sda_o  = 1'b0;
    // Register written only once a whole data byte is in
    assign commit = state == ST_WR_DATA && scl_fall
                    && bit_cnt == BITS_PER_BYTE && !bus_start
                    && !bus_stop;
    // Status snapshot taken on read clears the event flags
    assign rd_clr = state == ST_ADDR_AK && scl_fall && rx[0]
                    && !bus_start && !bus_stop;

    // ========================================================
    // Control register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            card_control <= CTRL_RESET;
        end else if (commit) begin
            card_control <= rx;
        end else if (answer || mute_hit) begin
            card_control[CTRL_WARM] <= 1'b0;
        end
    end

    // Sequencer and card clock controls follow the register
    assign session_o    = card_control[CTRL_SESSION];
    assign warm_reset_o = card_control[CTRL_WARM];
    assign vcc_3v_o     = card_control[CTRL_VCC_3V];
    assign cc.stop      = card_control[CTRL_CLK_STOP];
    assign cc.stop_high = card_control[CTRL_STOP_HI];
    assign cc.div       = card_control[CTRL_DIV_HI:CTRL_DIV_LO];
    assign card_clk_o   = cc.card_clk;

    cdi_card_clk u_card_clk (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .cc       (cc)
    );

    // Card I/O passes to host only while enabled, else released
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_side_io_o    <= 1'b1;
            host_side_io_oe_o <= 1'b0;
        end else begin
            host_side_io_o    <= card_io_i;
            host_side_io_oe_o <= card_control[CTRL_IO_EN];
        end
    end

    // ========================================================
    // Answer-to-reset window, counted in card clocks
    assign atr_begin = commit && ((rx[CTRL_SESSION] && !session_o)
                       || rx[CTRL_WARM]);
    assign answer    = atr_run && !card_io_i;
    assign mute_hit  = atr_run && cc.card_tick && !answer
                       && atr_cnt == 16'(MUTE_CLKS - 1);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            atr_run <= 1'b0;
            atr_cnt <= 16'h0000;
        end else if (atr_begin) begin
            atr_run <= 1'b1;
            atr_cnt <= 16'h0000;
        end else if (answer || mute_hit) begin
            atr_run <= 1'b0;
        end else if (atr_run && cc.card_tick) begin
            atr_cnt <= atr_cnt + 16'h0001;
        end
    end

    // Mute and early persist until the next session starts
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_mute  <= 1'b0;
            flag_early <= 1'b0;
        end else if (atr_begin && rx[CTRL_SESSION] && !session_o) begin
            flag_mute  <= 1'b0;
            flag_early <= 1'b0;
        end else begin
            if (mute_hit) begin
                flag_mute <= 1'b1;
            end
            if (answer && atr_cnt < 16'(EARLY_CLKS)) begin
                flag_early <= 1'b1;
            end
        end
    end

    // ========================================================
    // Sticky event flags; a new event beats a clearing read
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pres_q      <= 1'b0;
            flag_pres   <= 1'b0;
            flag_supply <= 1'b0;
            flag_overcurrent_heat_flag   <= 1'b0;
        end else begin
            pres_q      <= card_present_i;
            flag_pres   <= (card_present_i != pres_q)
                           || (flag_pres && !rd_clr);
            flag_supply <= supply_fault_i
                           || (flag_supply && !rd_clr);
            flag_overcurrent_heat_flag   <= (overcurrent_heat_flag_fault_i && vcc_on_i)
                           || (flag_overcurrent_heat_flag && !rd_clr);
        end
    end

    // Live levels registered so reset value is defined
    logic [7:0] live;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            live <= STATUS_RESET;
        end else begin
            live[STAT_PRES]   <= card_present_i;
            live[STAT_IO]     <= card_io_i;
            live[STAT_ACTIVE] <= vcc_on_i;
        end
    end

    always_comb begin
        status                = live;
        status[STAT_PRES_CHG] = flag_pres;
        status[STAT_SUPPLY]   = flag_supply;
        status[STAT_OVERCURRENT_HEAT_FLAG]     = flag_overcurrent_heat_flag;
        status[STAT_MUTE]     = flag_mute;
        status[STAT_EARLY]    = flag_early;
    end

    // Interrupt follows the latched events, active low
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_n_o <= 1'b1;
        end else begin
            irq_n_o <= !(flag_pres || flag_supply || flag_overcurrent_heat_flag);
        end
    end

    // ========================================================
    // Checks
    chk_ctrl_full_byte: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $changed(card_control[7:2]) |-> $past(commit))
        else $error("control changed without a full byte");
    chk_ack_low_drive: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (state == ST_ADDR_AK || state == ST_WR_AK) |-> sda_oe_o)
        else $error("acknowledge not driven low");
    chk_foreign_silent: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        state == ST_IGNORE |-> !sda_oe_o)
        else $error("driving sda on foreign address");
    chk_vcc_follows_write: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        commit |=> vcc_3v_o == $past(rx[CTRL_VCC_3V]))
        else $error("voltage select did not take written bit");
    chk_io_gate_off: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !card_control[CTRL_IO_EN] [*2] |-> !host_side_io_oe_o)
        else $error("host io driven while disabled");
    chk_warm_self_clear: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (mute_hit && !commit) |=> !warm_reset_o && flag_mute)
        else $error("warm reset not cleared on mute");
    chk_flag_read_clear: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (rd_clr && !supply_fault_i) |=> !flag_supply)
        else $error("supply flag not cleared by read");
    chk_irq_on_flag: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        supply_fault_i |=> ##1 !irq_n_o)
        else $error("interrupt missing after supply fault");
    chk_early_answer: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (answer && atr_cnt < 16'(EARLY_CLKS) && !atr_begin)
        |=> flag_early)
        else $error("early answer not flagged");

endmodule

//--- dv/cdi_host_model.sv
// Two-wire bus master model that drives the control block
`timescale 1ns/1ps
module cdi_host_model (
    // System
    input  wire logic clk_i,
    // Bus lines, SDA pulled low through sda_low_o
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // Idle bus: both lines released high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // Every change lands just after a falling clock edge
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // START, also usable as repeated START from SCL low
    task automatic start_cond();
        sda_low_o = 1'b0;
        wait_n(28);
        scl_o = 1'b1;
        wait_n(28);
        sda_low_o = 1'b1;
        wait_n(28);
        scl_o = 1'b0;
    endtask

    // One bit: 1.8 us low, 0.7 us high, 2.5 us period = 400 kHz
    task automatic bit_slot(input logic b, output logic r);
        wait_n(10);
        sda_low_o = !b; // Change well past the hold window
        wait_n(62);
        scl_o = 1'b1;
        wait_n(14);
        r = sda_i;
        wait_n(14);
        scl_o = 1'b0;
    endtask

    // Byte MSB first, then the ack slot driven with m
    task automatic xfer(input logic [7:0] d, input logic m,
                        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], r);
            q[i] = r;
        end
        bit_slot(m, r);
        ack = !r;
    endtask

    // Two-cycle SCL pulse in the low phase, at the spike limit
    task automatic spike_slot();
        wait_n(30);
        scl_o = 1'b1;
        wait_n(2);
        scl_o = 1'b0;
    endtask

    // STOP: SDA rises while SCL high
    task automatic stop_cond();
        wait_n(10);
        sda_low_o = 1'b1;
        wait_n(46);
        scl_o = 1'b1;
        wait_n(28);
        sda_low_o = 1'b0;
        wait_n(28);
    endtask
endmodule

//--- dv/card_interface_i2c_control_bench.sv
// Self-checking bench for the card interface control block
`timescale 1ns/1ps
module card_interface_i2c_control_bench;
    import cdi_pkg::*;
    // Stimulus and observed lines
    logic       clk_i, resetn_i, scl, sda_low, pres, cio, vcc, sflt, pflt;
    logic [2:0] sel;
    logic       sda_oe, sda_out, sess, warm, v3, cclk, hio, hio_oe, irq_n;
    logic [7:0] st;
    logic [1:0] ak;
    int         mismatches, check_count;
    // Open drain with pull-up: high unless someone pulls low
    wire        sda = !sda_low && (sda_oe ? sda_out : 1'b1);

    cdi_host_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
                         .sda_low_o(sda_low));
    // Short answer window keeps the run brief
    cdi_ctrl #(.MUTE_CLKS(50), .EARLY_CLKS(10)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_out), .sda_oe_o(sda_oe), .addr_select_bit0_i(sel[0]),
        .addr_select_bit1_i(sel[1]), .addr_select_bit2_i(sel[2]),
        .card_present_i(pres), .card_io_i(cio), .vcc_on_i(vcc),
        .supply_fault_i(sflt), .overcurrent_heat_flag_fault_i(pflt), .session_o(sess),
        .warm_reset_o(warm), .vcc_3v_o(v3), .card_clk_o(cclk),
        .host_side_io_o(hio), .host_side_io_oe_o(hio_oe), .irq_n_o(irq_n));

    // 40 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = !clk_i;
    end

    // ========================================================
    // Shared helpers
    task automatic check(input string what, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Address and data byte, bus left open for mid-frame checks
    task automatic wr_open(input logic [7:0] a, d);
        host.start_cond();
        host.xfer(a, 1'b1, st, ak[1]);
        host.xfer(d, 1'b1, st, ak[0]);
    endtask

    task automatic wr(input logic [7:0] a, d);
        wr_open(a, d);
        host.stop_cond();
    endtask

    // Status read ends with master nack, so ak[0] must read 0
    task automatic rd();
        host.start_cond();
        host.xfer({4'h4, sel, 1'b1}, 1'b1, st, ak[1]);
        host.xfer(8'hFF, 1'b1, st, ak[0]);
        host.stop_cond();
    endtask

    // ========================================================
    // Scenarios
    task automatic t_reset();
        check("reset outs", 8'({sess, warm, v3, hio_oe, irq_n}), 8'h01);
        rd();
        check("read acks", 8'(ak), 8'h2);
        check("status reset", st, STATUS_RESET);
    endtask

    task automatic t_addr();
        for (int s = 0; s < 8; s++) begin
            sel = 3'(s);
            wr({4'h4, sel, 1'b0}, s[0] ? 8'h84 : 8'h04);
            check("own acks", 8'(ak), 8'h3);
            check("io gate 3v", 8'({hio_oe, v3}), 8'({s[0], 1'b1}));
            wr({4'h4, ~sel, 1'b0}, 8'h00);
            check("foreign acks", 8'(ak), 8'h0);
            check("foreign kept", 8'({hio_oe, v3}), 8'({s[0], 1'b1}));
        end
        cio = 1'b0;
        host.wait_n(4);
        check("io passthrough", 8'(hio), 8'h0);
        cio = 1'b1;
    endtask

    // Byte cut short by STOP after four bits
    task automatic t_partial();
        logic r;
        host.start_cond();
        host.xfer({4'h4, sel, 1'b0}, 1'b1, st, r);
        repeat (4) host.bit_slot(1'b0, r);
        host.stop_cond();
        check("partial byte", 8'({hio_oe, v3}), 8'h3);
    endtask

    // SCL spike inside a data byte must not add a bit
    task automatic t_spike();
        logic r;
        host.start_cond();
        host.xfer({4'h4, sel, 1'b0}, 1'b1, st, r);
        for (int i = 7; i >= 0; i--) begin
            host.bit_slot(i == 2, r);
            if (i == 5) begin
                host.spike_slot();
            end
        end
        host.bit_slot(1'b1, r);
        check("spike ack", 8'(r), 8'h0);
        host.stop_cond();
        check("spike filtered", 8'({hio_oe, v3}), 8'h1);
    endtask

    task automatic t_clock();
        logic p;
        int   n;
        for (int d = 0; d < 4; d++) begin
            wr({4'h4, sel, 1'b0}, {1'b0, 2'(d), 5'h00});
            for (int k = 0; k < 2; k++) begin
                p = cclk;
                n = 0;
                while (cclk === p && n < 20) begin
                    host.wait_n(1);
                    n++;
                end
            end
            check("card clk half", 8'(n), 8'h08 >> d);
        end
        // Samples 8 cycles apart differ on a running divide-by-8 clock (half period 8)
        for (int lv = 0; lv < 2; lv++) begin
            wr({4'h4, sel, 1'b0}, lv ? 8'h18 : 8'h08);
            host.wait_n(20);
            check("stop level", 8'(cclk), 8'(lv));
            host.wait_n(8);
            check("stop held", 8'(cclk), 8'(lv));
        end
    endtask

    task automatic t_flags();
        pres = 1'b1;
        vcc = 1'b1;
        host.wait_n(3);
        sflt = 1'b1;
        pflt = 1'b1;
        host.wait_n(2);
        sflt = 1'b0;
        pflt = 1'b0;
        host.wait_n(4);
        check("irq low", 8'(irq_n), 8'h0);
        rd();
        check("flags set", st, 8'h9F);
        check("irq released", 8'(irq_n), 8'h1);
        rd();
        check("flags cleared", st, 8'h85);
    endtask

    // Mute card on warm start, then an early answer
    task automatic t_atr();
        wr_open({4'h4, sel, 1'b0}, 8'h03);
        check("session warm", 8'({sess, warm}), 8'h3);
        host.stop_cond();
        host.wait_n(900);
        check("warm cleared", 8'(warm), 8'h0);
        rd();
        check("mute status", st, 8'hA5);
        wr({4'h4, sel, 1'b0}, 8'h00);
        check("deactivate", 8'(sess), 8'h0);
        wr_open({4'h4, sel, 1'b0}, 8'h01);
        cio = 1'b0;
        host.stop_cond();
        rd();
        check("early status", st, 8'hC1);
        cio = 1'b1;
    endtask

    // Card pulled with supply off, then a reset in mid-run
    task automatic t_rst_mid();
        wr({4'h4, sel, 1'b0}, 8'h84);
        pres = 1'b0;
        vcc = 1'b0;
        pflt = 1'b1;
        host.wait_n(4);
        check("pres fall irq", 8'(irq_n), 8'h0);
        rd();
        pflt = 1'b0;
        check("overcurrent_heat_flag gated", st, 8'h46);
        resetn_i = 1'b0;
        host.wait_n(3);
        check("in reset", 8'({v3, hio_oe, irq_n, cclk}), 8'h02);
        resetn_i = 1'b1;
        host.wait_n(6);
        check("after reset", 8'({sess, v3, hio_oe, irq_n}), 8'h01);
        rd();
        check("status again", st, STATUS_RESET);
    endtask

    // ========================================================
    // Verdict, reached from the main sequence or the watchdog
    task automatic results();
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        resetn_i = 1'b0;
        {pres, vcc, sflt, pflt} = 4'h0;
        sel = 3'h0;
        cio = 1'b1;
        mismatches = 0;
        check_count = 0;
        repeat (6) @(negedge clk_i);
        resetn_i = 1'b1;
        host.wait_n(8);
        t_reset();
        t_addr();
        t_partial();
        t_spike();
        t_clock();
        t_flags();
        t_atr();
        t_rst_mid();
        results();
    end

    // Watchdog, about 70k cycles expected
    initial begin
        repeat (95000) @(posedge clk_i);
        mismatches++;
        results();
    end
endmodule
